// *** rtl/ecit_consts.svh ***
// Offsets, field positions, reset values and timing counts of the capture timer
`ifndef ECIT_CONSTS_SVH
`define ECIT_CONSTS_SVH

`define ECIT_OFS_MODE      8'h00
`define ECIT_OFS_CAP_FALL  8'h04
`define ECIT_OFS_CAP_RISE  8'h08
`define ECIT_OFS_CTRL      8'h0C
`define ECIT_OFS_IRQ_STAT  8'h10
`define ECIT_OFS_IRQ_MASK  8'h14

`define ECIT_BIT_OVF_HI    7
`define ECIT_BIT_OVF_LO    6
`define ECIT_BIT_OVERFLOW_IRQ_ENABLE      5
`define ECIT_BIT_CAPTURE_IRQ_EDGE_SELECT     4
`define ECIT_BIT_CCLR_HI   3
`define ECIT_BIT_CCLR_LO   2
`define ECIT_BIT_CKS_HI    1
`define ECIT_BIT_CKS_LO    0
`define ECIT_BIT_CAP_MODE  0
`define ECIT_BIT_IRQ_CAP   0
`define ECIT_BIT_IRQ_OVF   1

`define ECIT_MODE_RST      8'h00
`define ECIT_CNT_RST       8'h00
`define ECIT_CAP_RST       8'h00
`define ECIT_CNT_MAX       8'hFF

`define ECIT_TAP_DIV64     6'h3F
`define ECIT_TAP_DIV32     5'h1F
`define ECIT_WATCH_DIV4    2'h3

`endif

// *** rtl/ecit_pkg.sv ***
// Types shared by the capture timer
package ecit_pkg;

   typedef logic [7:0] ecit_count_t;

   typedef enum logic [1:0] {
      ECIT_CKS_DIV64 = 2'h0,
      ECIT_CKS_DIV32 = 2'h1,
      ECIT_CKS_DIV2  = 2'h2,
      ECIT_CKS_WATCH = 2'h3
   } ecit_cks_e;

   typedef enum logic [1:0] {
      ECIT_CLR_NONE = 2'h0,
      ECIT_CLR_FALL = 2'h1,
      ECIT_CLR_RISE = 2'h2,
      ECIT_CLR_BOTH = 2'h3
   } ecit_clr_e;

   typedef enum logic [1:0] {
      ECIT_RESP_OKAY   = 2'h0,
      ECIT_RESP_DECERR = 2'h3
   } ecit_resp_e;

   typedef enum logic [2:0] {
      ECIT_IDX_MODE = 3'h0,
      ECIT_IDX_FALL = 3'h1,
      ECIT_IDX_RISE = 3'h2,
      ECIT_IDX_CTRL = 3'h3,
      ECIT_IDX_STAT = 3'h4,
      ECIT_IDX_MASK = 3'h5,
      ECIT_IDX_NONE = 3'h7
   } ecit_idx_e;

endpackage

// *** rtl/ecit_timer.sv ***
// Edge capture / interval timer with AXI4-Lite register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`include "ecit_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ecit_timer
   import ecit_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              capture_in,
   input  wire logic              watch_clk_in,
   output logic                   irq
);

   // Register index of an address; used by both read and write paths
   function automatic ecit_idx_e addr_idx(input logic [ADDR_W-1:0] a);
      ecit_idx_e r;
      r = ECIT_IDX_NONE;
      unique case (a[7:0])
         `ECIT_OFS_MODE:     r = ECIT_IDX_MODE;
         `ECIT_OFS_CAP_FALL: r = ECIT_IDX_FALL;
         `ECIT_OFS_CAP_RISE: r = ECIT_IDX_RISE;
         `ECIT_OFS_CTRL:     r = ECIT_IDX_CTRL;
         `ECIT_OFS_IRQ_STAT: r = ECIT_IDX_STAT;
         `ECIT_OFS_IRQ_MASK: r = ECIT_IDX_MASK;
         default:            r = ECIT_IDX_NONE;
      endcase
      if ((a >> 8) != '0)
      begin
         r = ECIT_IDX_NONE;
      end
      return r;
   endfunction

   logic              aw_held_reg;
   logic              w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [7:0]        wdata_reg;
   logic              wlane_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              rvalid_reg;
   logic [1:0]        rresp_reg;
   logic [31:0]       rdata_reg;
   logic              wr_fire;
   logic              ar_fire;
   ecit_idx_e         wr_idx;
   ecit_idx_e         rd_idx;
   logic              wr_mode;

   logic [5:0]        cfg_reg;
   logic              ovf_hi_reg;
   logic              ovf_lo_reg;
   logic              armed_hi_reg;
   logic              armed_lo_reg;
   logic              cap_mode_reg;
   logic [1:0]        irq_stat_reg;
   logic [1:0]        irq_mask_reg;
   logic              irq_reg;

   ecit_count_t       cnt_reg;
   ecit_count_t       cap_fall_reg;
   ecit_count_t       cap_rise_reg;
   logic [5:0]        presc_reg;
   logic [1:0]        wdiv_reg;
   logic              wclk_s1_reg;
   logic              wclk_s2_reg;
   logic              wclk_s3_reg;
   logic              cap_s1_reg;
   logic              cap_s2_reg;
   logic              gated_prev_reg;

   ecit_cks_e         cks;
   ecit_clr_e         cclr;
   logic              overflow_irq_enable;
   logic              capture_irq_edge_select;
   logic              tick;
   logic              watch_edge;
   logic              gated;
   logic              rise;
   logic              fall;
   logic              edge_clear;
   logic              ovf_evt;
   logic              clr_hi;
   logic              clr_lo;
   logic [1:0]        irq_evt;

   assign cks   = ecit_cks_e'(cfg_reg[`ECIT_BIT_CKS_HI:`ECIT_BIT_CKS_LO]);
   assign cclr  = ecit_clr_e'(cfg_reg[`ECIT_BIT_CCLR_HI:`ECIT_BIT_CCLR_LO]);
   assign overflow_irq_enable  = cfg_reg[`ECIT_BIT_OVERFLOW_IRQ_ENABLE];
   assign capture_irq_edge_select = cfg_reg[`ECIT_BIT_CAPTURE_IRQ_EDGE_SELECT];

   // AXI4-Lite write channel: address and data taken in either order
   assign awready = !aw_held_reg && !bvalid_reg;
   assign wready  = !w_held_reg && !bvalid_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_idx  = addr_idx(awaddr_reg);
   assign wr_mode = wr_fire && wlane_reg && (wr_idx == ECIT_IDX_MODE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= awaddr;
      end
      else if (wr_fire)
      begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_reg <= 1'b0;
         wdata_reg  <= 8'h00;
         wlane_reg  <= 1'b0;
      end
      else if (wvalid && wready)
      begin
         w_held_reg <= 1'b1;
         wdata_reg  <= wdata[7:0];
         wlane_reg  <= wstrb[0];
      end
      else if (wr_fire)
      begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= ECIT_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= (wr_idx == ECIT_IDX_NONE) ? ECIT_RESP_DECERR : ECIT_RESP_OKAY;
      end
      else if (bready)
      begin
         bvalid_reg <= 1'b0;
      end
   end

   // AXI4-Lite read channel
   assign arready = !rvalid_reg;
   assign ar_fire = arvalid && arready;
   assign rd_idx  = addr_idx(araddr);
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= ECIT_RESP_OKAY;
         rdata_reg  <= '0;
      end
      else if (ar_fire)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= (rd_idx == ECIT_IDX_NONE) ? ECIT_RESP_DECERR : ECIT_RESP_OKAY;
         unique case (rd_idx)
            ECIT_IDX_MODE: rdata_reg <= {24'h00_0000, ovf_hi_reg, ovf_lo_reg, cfg_reg};
            ECIT_IDX_FALL: rdata_reg <= {24'h00_0000, cap_fall_reg};
            ECIT_IDX_RISE: rdata_reg <= {24'h00_0000, cap_rise_reg};
            ECIT_IDX_CTRL: rdata_reg <= {31'h0000_0000, cap_mode_reg};
            ECIT_IDX_STAT: rdata_reg <= {30'h0000_0000, irq_stat_reg};
            ECIT_IDX_MASK: rdata_reg <= {30'h0000_0000, irq_mask_reg};
            ECIT_IDX_NONE: rdata_reg <= '0;
            default:       rdata_reg <= '0;
         endcase
      end
      else if (rready)
      begin
         rvalid_reg <= 1'b0;
      end
   end

   // Control fields of the mode register; the counter has no address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_reg <= 6'(`ECIT_MODE_RST);
      end
      else if (wr_mode)
      begin
         cfg_reg <= wdata_reg[5:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap_mode_reg <= 1'b0;
         irq_mask_reg <= 2'h0;
      end
      else if (wr_fire && wlane_reg && (wr_idx == ECIT_IDX_CTRL))
      begin
         cap_mode_reg <= wdata_reg[`ECIT_BIT_CAP_MODE];
      end
      else if (wr_fire && wlane_reg && (wr_idx == ECIT_IDX_MASK))
      begin
         irq_mask_reg <= wdata_reg[1:0];
      end
   end

   // Clock taps; the watch clock is a foreign pin and is synchronised first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wclk_s1_reg <= 1'b0;
         wclk_s2_reg <= 1'b0;
         wclk_s3_reg <= 1'b0;
      end
      else
      begin
         wclk_s1_reg <= watch_clk_in;
         wclk_s2_reg <= wclk_s1_reg;
         wclk_s3_reg <= wclk_s2_reg;
      end
   end

   assign watch_edge = wclk_s2_reg && !wclk_s3_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         presc_reg <= 6'h00;
         wdiv_reg  <= 2'h0;
      end
      else
      begin
         presc_reg <= presc_reg + 6'h01;
         if (watch_edge)
         begin
            wdiv_reg <= wdiv_reg + 2'h1;
         end
      end
   end

   always_comb
   begin
      unique case (cks)
         ECIT_CKS_DIV64: tick = (presc_reg == `ECIT_TAP_DIV64);
         ECIT_CKS_DIV32: tick = (presc_reg[4:0] == `ECIT_TAP_DIV32);
         ECIT_CKS_DIV2:  tick = presc_reg[0];
         ECIT_CKS_WATCH: tick = watch_edge && (wdiv_reg == `ECIT_WATCH_DIV4);
      endcase
   end

   // Capture pin; in interval mode the pin is a plain port and reads low.
   // Toggling the mode bit with the pin high therefore makes an edge.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap_s1_reg     <= 1'b0;
         cap_s2_reg     <= 1'b0;
         gated_prev_reg <= 1'b0;
      end
      else
      begin
         cap_s1_reg     <= capture_in;
         cap_s2_reg     <= cap_s1_reg;
         gated_prev_reg <= gated;
      end
   end

   assign gated = cap_mode_reg && cap_s2_reg;
   assign rise  = gated && !gated_prev_reg;
   assign fall  = !gated && gated_prev_reg;

   always_comb
   begin
      unique case (cclr)
         ECIT_CLR_NONE: edge_clear = 1'b0;
         ECIT_CLR_FALL: edge_clear = fall;
         ECIT_CLR_RISE: edge_clear = rise;
         ECIT_CLR_BOTH: edge_clear = rise || fall;
      endcase
      edge_clear = edge_clear && cap_mode_reg;
   end

   assign ovf_evt = tick && !edge_clear && (cnt_reg == `ECIT_CNT_MAX);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_reg <= `ECIT_CNT_RST;
      end
      else if (edge_clear)
      begin
         cnt_reg <= `ECIT_CNT_RST;
      end
      else if (tick)
      begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   // Capture takes the count before any clear of the same edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap_fall_reg <= `ECIT_CAP_RST;
         cap_rise_reg <= `ECIT_CAP_RST;
      end
      else
      begin
         if (fall)
         begin
            cap_fall_reg <= cnt_reg;
         end
         if (rise)
         begin
            cap_rise_reg <= cnt_reg;
         end
      end
   end

   // Overflow flags: a zero write clears only after the flag was read as one
   assign clr_hi = wr_mode && !wdata_reg[`ECIT_BIT_OVF_HI] && armed_hi_reg;
   assign clr_lo = wr_mode && !wdata_reg[`ECIT_BIT_OVF_LO] && armed_lo_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ovf_hi_reg <= 1'b0;
         ovf_lo_reg <= 1'b0;
      end
      else
      begin
         if (ovf_evt && gated)
         begin
            ovf_hi_reg <= 1'b1;
         end
         else if (clr_hi)
         begin
            ovf_hi_reg <= 1'b0;
         end
         if (ovf_evt && !gated)
         begin
            ovf_lo_reg <= 1'b1;
         end
         else if (clr_lo)
         begin
            ovf_lo_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         armed_hi_reg <= 1'b0;
         armed_lo_reg <= 1'b0;
      end
      else
      begin
         if (clr_hi)
         begin
            armed_hi_reg <= 1'b0;
         end
         else if (ar_fire && (rd_idx == ECIT_IDX_MODE) && ovf_hi_reg)
         begin
            armed_hi_reg <= 1'b1;
         end
         if (clr_lo)
         begin
            armed_lo_reg <= 1'b0;
         end
         else if (ar_fire && (rd_idx == ECIT_IDX_MODE) && ovf_lo_reg)
         begin
            armed_lo_reg <= 1'b1;
         end
      end
   end

   // Interrupt requests: sticky, write one to clear, set wins
   assign irq_evt[`ECIT_BIT_IRQ_CAP] = capture_irq_edge_select ? fall : rise;
   assign irq_evt[`ECIT_BIT_IRQ_OVF] = ovf_evt && overflow_irq_enable;

   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_irq_bit
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               irq_stat_reg[i] <= 1'b0;
            end
            else if (irq_evt[i])
            begin
               irq_stat_reg[i] <= 1'b1;
            end
            else if (wr_fire && wlane_reg && (wr_idx == ECIT_IDX_STAT) && wdata_reg[i])
            begin
               irq_stat_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   assign irq = irq_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_write_taken;
      aw_held_reg && w_held_reg && !bvalid_reg;
   endsequence

   sequence s_rise_selected;
      rise && !capture_irq_edge_select;
   endsequence

   chk_count_step: assert property (tick && !edge_clear |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("counter did not step on tick");
   chk_div2_rate: assert property ((cks == ECIT_CKS_DIV2) && $past(cks == ECIT_CKS_DIV2)
      |-> tick != $past(tick))
      else $error("divide by two tap wrong");
   chk_cap_fall: assert property (fall |=> cap_fall_reg == $past(cnt_reg))
      else $error("falling capture lost");
   chk_cap_rise: assert property (rise |=> cap_rise_reg == $past(cnt_reg))
      else $error("rising capture lost");
   chk_irq_edge_sel: assert property (s_rise_selected |=> irq_stat_reg[0])
      else $error("capture request not raised");
   chk_ovf_level: assert property (ovf_evt |=> ($past(gated) ? ovf_hi_reg : ovf_lo_reg))
      else $error("overflow flag level wrong");
   chk_flag_hw_set: assert property ($rose(ovf_hi_reg) |-> $past(ovf_evt && gated))
      else $error("high flag set without overflow");
   chk_flag_clear: assert property ($fell(ovf_lo_reg) |-> $past(clr_lo))
      else $error("low flag cleared without read and zero write");
   chk_interval_noclr: assert property (!cap_mode_reg && $past(!cap_mode_reg) && cnt_reg == 8'h00
      |-> $past(cnt_reg) == 8'hFF || $past(cnt_reg) == 8'h00)
      else $error("counter cleared in interval mode");
   chk_ovf_irq_gate: assert property ($rose(irq_stat_reg[1]) |-> $past(ovf_evt && overflow_irq_enable))
      else $error("overflow request without enable");
   chk_irq_out: assert property (|(irq_stat_reg & irq_mask_reg) |=> irq)
      else $error("irq output not raised");
   chk_write_answer: assert property (s_write_taken |=> bvalid ##0 !awready && !wready)
      else $error("write response missing");

endmodule // ecit_timer

`default_nettype wire

// *** tb/ecit_pulse_src.sv ***
// Pulse source model that drives the capture pin of the timer
`timescale 1ns/1ps
`default_nettype none

module ecit_pulse_src
(
   input  wire logic aclk,
   output var logic  pin
);

   initial pin = 1'b0;

   // Levels shorter than two clocks can slip past the synchroniser
   task automatic hold(input logic lvl, input int cyc);
      @(posedge aclk);
      pin <= lvl;
      repeat ((cyc < 2 ? 2 : cyc) - 1) @(posedge aclk);
   endtask

endmodule // ecit_pulse_src

`default_nettype wire

// *** tb/edge_capture_interval_timer8_bench.sv ***
// Self-checking bench for the edge capture interval timer
`timescale 1ns/1ps
`default_nettype none

module edge_capture_interval_timer8_bench
   import ecit_pkg::*;
;

   typedef struct packed
   {
      logic [31:0] exp;
      logic [31:0] mask;
      logic [1:0]  resp;
   } ecit_note_s;

   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, capture_in, watch_clk_in, irq;
   logic [7:0]  awaddr, araddr;
   logic [2:0]  awprot, arprot;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] lfsr;
   int          errors = 0;
   int          check_count = 0;
   int          i;
   int          ks[4] = '{1280, 640, 40, 740};
   ecit_note_s  notes[$];
   logic [1:0]  bnotes[$];
   ecit_note_s  mon_note;
   ecit_count_t fall_v, rise_v;

   ecit_timer dut
   (
      .aclk (aclk), .aresetn (aresetn), .awaddr (awaddr), .awprot (awprot),
      .awvalid (awvalid), .awready (awready), .wdata (wdata), .wstrb (wstrb),
      .wvalid (wvalid), .wready (wready), .bresp (bresp), .bvalid (bvalid),
      .bready (bready), .araddr (araddr), .arprot (arprot), .arvalid (arvalid),
      .arready (arready), .rdata (rdata), .rresp (rresp), .rvalid (rvalid),
      .rready (rready), .capture_in (capture_in), .watch_clk_in (watch_clk_in),
      .irq (irq)
   );

   ecit_pulse_src src
   (
      .aclk (aclk),
      .pin  (capture_in)
   );

   initial aclk = 1'b0;
   always #4 aclk = ~aclk;
   // Watch clock phase unrelated to aclk on purpose
   initial watch_clk_in = 1'b0;
   always #37 watch_clk_in = ~watch_clk_in;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Prescaler phase is free-running, so one count either way is accepted
   function automatic ecit_count_t fit(input ecit_count_t v, input ecit_count_t e);
      return (v == e || v == e + 8'h01 || v == e - 8'h01) ? e : v;
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      lfsr = lfsr_next(lfsr);
      @(posedge aclk);
      bnotes.push_back((a > 8'h14) ? 2'h3 : 2'h0);
      awaddr <= a;
      awprot <= lfsr[2:0];
      awvalid <= 1'b1;
      wdata <= {lfsr, lfsr[7:0], d};
      wstrb <= {lfsr[5:3], 1'b1};
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1)
         @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      lfsr = lfsr_next(lfsr);
      @(posedge aclk);
      notes.push_back('{e, m, (a > 8'h14) ? 2'h3 : 2'h0});
      araddr <= a;
      arprot <= lfsr[2:0];
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
         @(posedge aclk);
      while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1)
         @(posedge aclk);
      rd_val = rdata;
      rready <= 1'b0;
   endtask

   // Falling edge, K cycles, rising edge, K cycles, falling edge
   task automatic trip(input logic [7:0] cfg, input int k, input ecit_count_t e);
      wr(8'h00, 8'hC0 | cfg);
      src.hold(1'b1, 12);
      src.hold(1'b0, k);
      src.hold(1'b1, k);
      src.hold(1'b0, 12);
      rd(8'h04, 32'h0, 32'h0);
      fall_v = rd_val[7:0];
      rd(8'h08, 32'h0, 32'h0);
      rise_v = rd_val[7:0];
      if (cfg[2])
         chk("rise_cap", fit(rise_v, e), e);
      if (cfg[3])
         chk("fall_cap", fit(fall_v, e), e);
      else
         chk("cap_span", fit(fall_v - rise_v, e), e);
   endtask

   task automatic edge_irq(input logic lvl, input logic [31:0] e);
      wr(8'h10, 8'h01);
      src.hold(lvl, 10);
      rd(8'h10, e, 32'h1);
   endtask

   always @(posedge aclk)
   begin
      if (rvalid === 1'b1 && rready === 1'b1)
      begin
         mon_note = notes.pop_front();
         chk("rdata", rdata & mon_note.mask, mon_note.exp & mon_note.mask);
         chk("rresp", {30'h0, rresp}, {30'h0, mon_note.resp});
      end
      if (bvalid === 1'b1 && bready === 1'b1)
      begin
         chk("bresp", {30'h0, bresp}, {30'h0, bnotes.pop_front()});
      end
   end

   initial
   begin
      repeat (40000) @(posedge aclk);
      errors++;
      stop_test();
   end

   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
      lfsr = 16'hE67E;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      chk("irq_reset", {31'h0, irq}, 32'h0);
      for (i = 0; i <= 24; i += 4)
         rd(i[7:0], 32'h0, 32'hFFFF_FFFF);
      wr(8'h04, 8'hA5);
      wr(8'h08, 8'h5A);
      wr(8'h18, 8'h33);
      rd(8'h04, 32'h0, 32'hFFFF_FFFF);
      rd(8'h08, 32'h0, 32'hFFFF_FFFF);
      wr(8'h0C, 8'h01);
      for (i = 0; i < 4; i++)
         trip(8'h0C | i[7:0], ks[i], 8'h14);
      for (i = 0; i < 4; i++)
         trip({4'h0, i[1:0], 2'h2}, 40, 8'h14);
      // Interval mode with edge clearing armed: pin activity must not clear
      wr(8'h0C, 8'h00);
      rd(8'h00, 32'h0, 32'h0);
      wr(8'h00, 8'h0E);
      wr(8'h10, 8'h03);
      for (i = 0; i < 20; i++)
      begin
         lfsr = lfsr_next(lfsr);
         src.hold(lfsr[0], 28);
      end
      rd(8'h10, 32'h0, 32'h2);
      rd(8'h00, 32'h4E, 32'hFF);
      wr(8'h00, 8'h2E);
      wr(8'h10, 8'h03);
      wr(8'h14, 8'h02);
      for (i = 0; i < 600 && irq !== 1'b1; i++)
         @(posedge aclk);
      chk("irq_ovf", {31'h0, irq}, 32'h1);
      rd(8'h10, 32'h2, 32'h2);
      wr(8'h00, 8'h2E);
      rd(8'h00, 32'h6E, 32'hFF);
      wr(8'h00, 8'hEE);
      rd(8'h00, 32'h6E, 32'hFF);
      wr(8'h00, 8'h2C);
      rd(8'h00, 32'h2C, 32'hFF);
      wr(8'h10, 8'h02);
      repeat (3) @(posedge aclk);
      chk("irq_ovf_clear", {31'h0, irq}, 32'h0);
      // Capture mode with the pin held high through a wrap
      src.hold(1'b1, 4);
      wr(8'h0C, 8'h01);
      wr(8'h00, 8'h0E);
      src.hold(1'b1, 600);
      rd(8'h00, 32'h80, 32'h80);
      wr(8'h14, 8'h01);
      wr(8'h00, 8'hC2);
      src.hold(1'b0, 10);
      edge_irq(1'b1, 32'h1);
      chk("irq_cap", {31'h0, irq}, 32'h1);
      edge_irq(1'b0, 32'h0);
      wr(8'h00, 8'hD2);
      edge_irq(1'b1, 32'h0);
      edge_irq(1'b0, 32'h1);
      wr(8'h14, 8'h00);
      repeat (3) @(posedge aclk);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      stop_test();
   end

endmodule // edge_capture_interval_timer8_bench

`default_nettype wire
